/* compact16_pkg.sv */
package compact16_pkg;
	localparam int          MAJ_LSB   = 11;
	localparam int          MAJ_W     = 5;
	localparam int          REG_W     = 3;
	localparam int          RX_LSB    = 8;
	localparam int          RY_LSB    = 5;
	localparam int          RZ_LSB    = 2;
	localparam int          SA_LSB    = 2;
	localparam int          GPR_W     = 5;
	localparam int          IMM_W     = 26;
	localparam logic [4:0]  SA_ZERO_AS = 5'h08;
	// Positions inside the first (prefix) halfword, word bit minus 16; SV_SAVE to SV_S1, ADDIMM_F and ROT_LSB index the instruction halfword
	localparam int          PX_HI_LSB = 5;
	localparam int          PX_SA_LSB = 6;
	localparam int          PX_S5     = 5;
	localparam int          PX_SEL_LSB = 8;
	localparam int          PX_SWAP   = 10;
	localparam int          PX_AI_LSB = 4;
	localparam int          PX_FR_LSB = 4;
	localparam int          SV_SAVE   = 7;
	localparam int          SV_RA     = 6;
	localparam int          SV_S0     = 5;
	localparam int          SV_S1     = 4;
	localparam int          ADDIMM_F  = 4;
	localparam int          ROT_LSB   = 3;
	// Immediate widths reported with each instruction
	localparam logic [4:0]  IW_FOUR   = 5'h04;
	localparam logic [4:0]  IW_FIVE   = 5'h05;
	localparam logic [4:0]  IW_EIGHT  = 5'h08;
	localparam logic [4:0]  IW_ELEVEN = 5'h0B;
	localparam logic [4:0]  IW_XAI    = 5'h0F;
	localparam logic [4:0]  IW_EXT    = 5'h10;
	localparam logic [4:0]  IW_CALL   = 5'h1A;
	// Major opcodes
	localparam logic [4:0]  MAJ_ADD_SP     = 5'h00;
	localparam logic [4:0]  MAJ_ADD_PC     = 5'h01;
	localparam logic [4:0]  MAJ_BRANCH     = 5'h02;
	localparam logic [4:0]  MAJ_CALL_ABS   = 5'h03;
	localparam logic [4:0]  MAJ_BR_ZERO    = 5'h04;
	localparam logic [4:0]  MAJ_BR_NZERO   = 5'h05;
	localparam logic [4:0]  MAJ_SHIFT      = 5'h06;
	localparam logic [4:0]  MAJ_ADD_IMM    = 5'h08;
	localparam logic [4:0]  MAJ_ADD_EIGHT  = 5'h09;
	localparam logic [4:0]  MAJ_LESS_IMM   = 5'h0A;
	localparam logic [4:0]  MAJ_LESS_IMMU  = 5'h0B;
	localparam logic [4:0]  MAJ_EIGHT_FUNC = 5'h0C;
	localparam logic [4:0]  MAJ_LOAD_IMM   = 5'h0D;
	localparam logic [4:0]  MAJ_CMP_IMM    = 5'h0E;
	localparam logic [4:0]  MAJ_LD_BYTE    = 5'h10;
	localparam logic [4:0]  MAJ_LD_HALF    = 5'h11;
	localparam logic [4:0]  MAJ_LD_SP      = 5'h12;
	localparam logic [4:0]  MAJ_LD_WORD    = 5'h13;
	localparam logic [4:0]  MAJ_LD_BYTEU   = 5'h14;
	localparam logic [4:0]  MAJ_LD_HALFU   = 5'h15;
	localparam logic [4:0]  MAJ_LD_PC      = 5'h16;
	localparam logic [4:0]  MAJ_ST_BYTE    = 5'h18;
	localparam logic [4:0]  MAJ_ST_HALF    = 5'h19;
	localparam logic [4:0]  MAJ_ST_SP      = 5'h1A;
	localparam logic [4:0]  MAJ_ST_WORD    = 5'h1B;
	localparam logic [4:0]  MAJ_THREE_REG  = 5'h1C;
	localparam logic [4:0]  MAJ_REG_REG    = 5'h1D;
	localparam logic [4:0]  MAJ_PREFIX     = 5'h1E;
	// Eight-bit function group codes
	localparam logic [2:0]  F8_BR_TZERO    = 3'h0;
	localparam logic [2:0]  F8_BR_TNZERO   = 3'h1;
	localparam logic [2:0]  F8_SPILL_FILL  = 3'h4;
	localparam logic [2:0]  F8_TO_FULL     = 3'h5;
	localparam logic [2:0]  F8_RSVD        = 3'h6;
	localparam logic [2:0]  F8_FROM_FULL   = 3'h7;
	// Register-register functions and three-register functions
	localparam logic [4:0]  RRF_REG_JUMP   = 5'h00;
	localparam logic [4:0]  RRF_CONVERT    = 5'h11;
	localparam logic [1:0]  TRF_ADD        = 2'h1;
	localparam logic [1:0]  TRF_SUB        = 2'h3;
	localparam logic [2:0]  SUB_RSV_A      = 3'h3;
	localparam logic [2:0]  SUB_RSV_B      = 3'h7;
	localparam int          SUB_COMPACT    = 2;
	// Register map
	localparam int          APB_AW         = 8;
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam logic [7:0]  REG_ISSUED     = 8'h08;
	localparam logic [7:0]  REG_RSVD       = 8'h0C;
	localparam int          CTRL_EN_BIT    = 0;
	localparam logic        CTRL_EN_RST    = 1'b1;
	localparam int          CNT_W          = 16;
	// Macro table, fixed at build time; default is one no-op per select
	localparam int          MACRO_SEL      = 8;
	localparam int          MACRO_STEPS    = 2;
	localparam logic [31:0] MACRO_TMPL [0:MACRO_SEL-1][0:MACRO_STEPS-1] =
		'{default: 32'h0000_0000};
	localparam logic [1:0]  MACRO_LEN [0:MACRO_SEL-1] = '{default: 2'h1};

	typedef enum logic [1:0] {
		ST_RUN     = 2'b00,
		ST_SLOT    = 2'b01,
		ST_RESOLVE = 2'b10,
		ST_MACRO   = 2'b11
	} flow_state_t;

	typedef struct packed {
		logic [4:0]  maj;
		logic [2:0]  r1;
		logic [2:0]  r2;
		logic [2:0]  r3;
		logic [2:0]  sub;
		logic [4:0]  func;
		logic [25:0] imm;
		logic [4:0]  imm_w;
		logic [4:0]  sa;
		logic        sa_msb;
		logic [4:0]  gpr;
		logic [3:0]  spill;
		logic [7:0]  frame;
		logic [2:0]  xs;
		logic [3:0]  ar;
		logic        ext;
		logic        swap;
		logic        slot_instr;
		logic        has_slot;
		logic        rsvd;
		logic [31:0] addr;
	} dec_t;
endpackage

/* macro_expander.sv */
`timescale 1ns/1ps
`default_nettype none
module macro_expander (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       start,
	input  wire logic [2:0] sel,
	input  wire logic [2:0] p4,
	input  wire logic [4:0] p3,
	input  wire logic [2:0] p2,
	input  wire logic [2:0] p1,
	input  wire logic [4:0] p0,
	output logic            busy,
	output logic            native_valid,
	output logic [31:0]     native_word
);
	import compact16_pkg::*;

	logic [2:0]  sel_r;
	logic [18:0] par_r;
	logic [1:0]  step_r;
	logic        busy_r;
	logic        valid_r;
	logic [31:0] word_r;

	// Substitution slots: rs takes p3, rt p2, immediate {p4,p1,p0} shifted left by 2
	wire [31:0] subst = {6'h00, par_r[15:11], 2'h0, par_r[10:8], 3'h0,
		par_r[18:16], par_r[7:5], par_r[4:0], 2'h0};
	wire [31:0] word_nxt = MACRO_TMPL[sel_r][step_r[0]] | subst;
	wire        last = (step_r == MACRO_LEN[sel_r] - 2'h1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sel_r   <= 3'h0;
			par_r   <= 19'h0;
			step_r  <= 2'h0;
			busy_r  <= 1'b0;
			valid_r <= 1'b0;
			word_r  <= 32'h0000_0000;
		end else if (start) begin
			sel_r   <= sel;
			par_r   <= {p4, p3, p2, p1, p0};
			step_r  <= 2'h0;
			busy_r  <= 1'b1;
			valid_r <= 1'b0;
		end else begin
			valid_r <= busy_r;
			if (busy_r) begin
				word_r <= word_nxt;
				step_r <= step_r + 2'h1;
				busy_r <= !last;
			end
		end
	end

	assign busy         = busy_r;
	assign native_valid = valid_r;
	assign native_word  = word_r;
endmodule
`default_nettype wire

/* compact16_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module compact16_decoder (
	input  wire logic                              clk,
	input  wire logic                              nrst,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [compact16_pkg::APB_AW-1:0]  paddr,
	input  wire logic [31:0]                       pwdata,
	output logic [31:0]                            prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	input  wire logic                              fetch_valid,
	input  wire logic [31:0]                       fetch_word,
	input  wire logic [31:0]                       fetch_addr,
	input  wire logic                              fetch_skip_first,
	output logic                                   fetch_ready,
	input  wire logic                              resolve_valid,
	input  wire logic                              resolve_taken,
	output logic                                   redirect,
	output logic                                   dec_valid,
	output logic [4:0]                             major_opcode,
	output logic [2:0]                             first_reg_spec,
	output logic [2:0]                             second_reg_spec,
	output logic [2:0]                             third_reg_spec,
	output logic [2:0]                             sub_func,
	output logic [4:0]                             func_code,
	output logic [compact16_pkg::IMM_W-1:0]        imm_value,
	output logic [4:0]                             imm_width,
	output logic [4:0]                             shift_amount_field,
	output logic                                   shift_amount_msb,
	output logic [compact16_pkg::GPR_W-1:0]        full_gpr_number,
	output logic [3:0]                             spill_select,
	output logic [7:0]                             frame_adjust,
	output logic [2:0]                             extra_saved_regs,
	output logic [3:0]                             argument_regs_field,
	output logic                                   is_extended,
	output logic                                   mode_swap,
	output logic                                   in_delay_slot,
	output logic                                   has_delay_slot,
	output logic                                   reserved_instr,
	output logic [31:0]                            restart_addr,
	output logic                                   native_valid,
	output logic [31:0]                            native_word
);
	import compact16_pkg::*;

	flow_state_t state_r, state_nxt;
	dec_t        dec_r, d;
	logic        dec_valid_r;
	logic [31:0] word_r, addr_r, pend_addr_r;
	logic [15:0] pend_hw_r;
	logic        buf_full_r, phase_r, pend_r, fetch_ready_r, redirect_r;
	logic        ctrl_en_r, pready_r, pslverr_r;
	logic [31:0] prdata_r;
	logic [CNT_W-1:0] issued_r, rsvd_cnt_r;
	logic        is_macro, cf_slot, cf_cond, cf_compact, flush;
	logic        exp_busy;

	// Halfword selection and field extraction
	wire        consume   = buf_full_r & ctrl_en_r & (state_r == ST_RUN | state_r == ST_SLOT);
	wire [15:0] hw        = phase_r ? word_r[15:0] : word_r[31:16];
	wire [31:0] hw_addr   = {addr_r[31:2], phase_r, 1'b0};
	wire [15:0] px        = pend_hw_r;
	wire [4:0]  maj       = hw[MAJ_LSB +: MAJ_W];
	wire [2:0]  f8        = hw[RX_LSB +: REG_W];
	wire [2:0]  sub       = hw[RY_LSB +: REG_W];
	wire [2:0]  sa_short  = hw[SA_LSB +: REG_W];
	wire        pend_call = (px[MAJ_LSB +: MAJ_W] == MAJ_CALL_ABS);
	wire        ext       = pend_r & ~pend_call;
	wire        starts_pair = ~pend_r & (maj == MAJ_PREFIX | maj == MAJ_CALL_ABS);
	wire        issue     = consume & ~starts_pair;
	wire        mid_zero  = (hw[RY_LSB +: REG_W] == 3'h0);
	wire [15:0] imm16     = {px[4:0], px[PX_HI_LSB +: 6], hw[4:0]};
	wire [14:0] imm15     = {px[3:0], px[PX_AI_LSB +: 7], hw[3:0]};
	wire        cls_ri8   = maj inside {MAJ_ADD_SP, MAJ_ADD_PC, MAJ_BR_ZERO, MAJ_BR_NZERO,
		MAJ_ADD_EIGHT, MAJ_LESS_IMM, MAJ_LESS_IMMU, MAJ_LOAD_IMM, MAJ_CMP_IMM,
		MAJ_LD_SP, MAJ_LD_PC, MAJ_ST_SP};
	wire        cls_rri5  = maj inside {MAJ_LD_BYTE, MAJ_LD_HALF, MAJ_LD_WORD, MAJ_LD_BYTEU,
		MAJ_LD_HALFU, MAJ_ST_BYTE, MAJ_ST_HALF, MAJ_ST_WORD};
	wire        no_prefix = maj inside {MAJ_CALL_ABS, MAJ_REG_REG, MAJ_PREFIX}
		| (maj == MAJ_EIGHT_FUNC & f8 inside {F8_TO_FULL, F8_RSVD, F8_FROM_FULL});
	wire        flush_load = fetch_valid & fetch_ready_r & ~flush;
	wire        buf_full_nxt = flush ? 1'b0 : flush_load ? 1'b1
		: (consume & phase_r) ? 1'b0 : buf_full_r;
	wire        exp_start = issue & is_macro & (state_r == ST_RUN);

	always_comb begin
		d            = '0;
		is_macro     = 1'b0;
		cf_slot      = 1'b0;
		cf_cond      = 1'b0;
		cf_compact   = 1'b0;
		d.maj        = maj;
		d.r1         = hw[RX_LSB +: REG_W];
		d.r2         = hw[RY_LSB +: REG_W];
		d.r3         = hw[RZ_LSB +: REG_W];
		d.func       = {3'h0, hw[1:0]};
		d.ext        = ext;
		d.addr       = pend_r ? pend_addr_r : hw_addr;
		d.slot_instr = (state_r == ST_SLOT);
		if (pend_r & pend_call) begin
			d.maj   = MAJ_CALL_ABS;
			d.imm   = {px[4:0], px[PX_HI_LSB +: 5], hw};
			d.imm_w = IW_CALL;
			d.swap  = px[PX_SWAP];
			cf_slot = 1'b1;
		end else begin
			case (maj)
				MAJ_BRANCH: begin
					d.imm      = ext ? {10'h000, imm16} : {15'h0000, hw[10:0]};
					d.imm_w    = ext ? IW_EXT : IW_ELEVEN;
					d.rsvd     = ext & (hw[10:5] != 6'h00);
					cf_compact = 1'b1;
				end
				MAJ_SHIFT: begin
					if (ext) begin
						d.sa     = px[PX_SA_LSB +: 5];
						d.sa_msb = px[PX_S5];
					end else begin
						d.sa = (sa_short == 3'h0) ? SA_ZERO_AS : {2'h0, sa_short};
					end
				end
				MAJ_ADD_IMM: begin
					d.func  = {4'h0, hw[ADDIMM_F]};
					d.imm   = ext ? {11'h000, imm15} : {22'h000000, hw[3:0]};
					d.imm_w = ext ? IW_XAI : IW_FOUR;
				end
				MAJ_EIGHT_FUNC: begin
					d.func  = {2'h0, f8};
					d.imm   = ext ? {10'h000, imm16} : {18'h00000, hw[7:0]};
					d.imm_w = ext ? IW_EXT : IW_EIGHT;
					d.rsvd  = ext & ~mid_zero & (f8 != F8_SPILL_FILL);
					cf_cond = (f8 == F8_BR_TZERO) | (f8 == F8_BR_TNZERO);
					case (f8)
						F8_SPILL_FILL: begin
							d.spill = {hw[SV_SAVE], hw[SV_RA], hw[SV_S0], hw[SV_S1]};
							d.frame = {ext ? px[PX_FR_LSB +: 4] : 4'h0, hw[3:0]};
							d.xs    = ext ? px[PX_SEL_LSB +: 3] : 3'h0;
							d.ar    = ext ? px[3:0] : 4'h0;
							d.imm   = '0;
							d.imm_w = ext ? IW_EIGHT : IW_FOUR;
						end
						F8_TO_FULL: begin
							d.gpr = {hw[ROT_LSB +: 2], hw[RY_LSB +: 3]};
							d.r3  = hw[2:0];
							d.r2  = 3'h0;
						end
						F8_FROM_FULL: d.gpr = hw[GPR_W-1:0];
						F8_RSVD: d.rsvd = 1'b1;
						default: d.rsvd = d.rsvd;
					endcase
				end
				MAJ_THREE_REG: begin
					if (ext) begin
						is_macro = 1'b1;
						d.xs     = px[PX_SEL_LSB +: 3];
					end else begin
						d.rsvd = (hw[1:0] != TRF_ADD) & (hw[1:0] != TRF_SUB);
					end
				end
				MAJ_REG_REG: begin
					d.func = hw[4:0];
					if (hw[4:0] == RRF_REG_JUMP | hw[4:0] == RRF_CONVERT) begin
						d.sub = sub;
						d.r2  = 3'h0;
					end
					if (hw[4:0] == RRF_REG_JUMP) begin
						d.rsvd     = (sub == SUB_RSV_A) | (sub == SUB_RSV_B);
						cf_compact = sub[SUB_COMPACT];
						cf_slot    = ~sub[SUB_COMPACT];
					end
				end
				default: begin
					if (cls_ri8) begin
						d.imm   = ext ? {10'h000, imm16} : {18'h00000, hw[7:0]};
						d.imm_w = ext ? IW_EXT : IW_EIGHT;
						d.rsvd  = ext & ~mid_zero;
						cf_cond = (maj == MAJ_BR_ZERO) | (maj == MAJ_BR_NZERO);
					end else if (cls_rri5) begin
						d.imm   = ext ? {10'h000, imm16} : {21'h000000, hw[4:0]};
						d.imm_w = ext ? IW_EXT : IW_FIVE;
					end else begin
						d.rsvd = 1'b1;
					end
				end
			endcase
			if (ext & no_prefix) begin
				d.rsvd = 1'b1;
			end
		end
		d.has_slot = cf_slot & ~d.rsvd;
		if (d.rsvd) begin
			is_macro   = 1'b0;
			cf_slot    = 1'b0;
			cf_cond    = 1'b0;
			cf_compact = 1'b0;
		end
	end

	// Flow control around jumps and branches
	always_comb begin
		state_nxt = state_r;
		flush     = 1'b0;
		case (state_r)
			ST_RUN, ST_SLOT: begin
				if (issue) begin
					if (state_r == ST_SLOT) begin
						flush     = 1'b1;
						state_nxt = ST_RUN;
					end else if (is_macro) begin
						state_nxt = ST_MACRO;
					end else if (cf_slot) begin
						state_nxt = ST_SLOT;
					end else if (cf_cond) begin
						state_nxt = ST_RESOLVE;
					end else if (cf_compact) begin
						flush = 1'b1;
					end
				end
			end
			ST_RESOLVE: begin
				if (resolve_valid) begin
					state_nxt = ST_RUN;
					flush     = resolve_taken;
				end
			end
			ST_MACRO: begin
				if (!exp_busy) begin
					state_nxt = ST_RUN;
				end
			end
			default: state_nxt = ST_RUN;
		endcase
	end

	// Word buffer, pairing and decoded output
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r       <= ST_RUN;
			buf_full_r    <= 1'b0;
			phase_r       <= 1'b0;
			word_r        <= 32'h0000_0000;
			addr_r        <= 32'h0000_0000;
			pend_r        <= 1'b0;
			pend_hw_r     <= 16'h0000;
			pend_addr_r   <= 32'h0000_0000;
			fetch_ready_r <= 1'b1;
			redirect_r    <= 1'b0;
			dec_valid_r   <= 1'b0;
			dec_r         <= '0;
		end else begin
			state_r       <= state_nxt;
			buf_full_r    <= buf_full_nxt;
			fetch_ready_r <= ~buf_full_nxt;
			redirect_r    <= flush;
			dec_valid_r   <= issue;
			if (flush_load) begin
				word_r  <= fetch_word;
				addr_r  <= fetch_addr;
				phase_r <= fetch_skip_first;
			end else if (consume) begin
				phase_r <= ~phase_r;
			end
			// Pending half stays until its partner arrives
			if (flush) begin
				pend_r <= 1'b0;
			end else if (consume) begin
				pend_r <= starts_pair;
			end
			if (consume & starts_pair) begin
				pend_hw_r   <= hw;
				pend_addr_r <= hw_addr;
			end
			if (issue) begin
				dec_r <= d;
			end
		end
	end

	// Register slave; answers one cycle into the access phase
	wire        apb_acc  = psel & penable & ~pready_r;
	wire        apb_done = psel & penable & pready_r;
	wire        a_ctrl   = (paddr == REG_CTRL);
	wire        a_stat   = (paddr == REG_STATUS);
	wire        a_iss    = (paddr == REG_ISSUED);
	wire        a_rsv    = (paddr == REG_RSVD);
	wire        a_hit    = a_ctrl | a_stat | a_iss | a_rsv;
	wire [31:0] rd_mux   = a_ctrl ? {31'h0, ctrl_en_r}
		: a_stat ? {27'h0, exp_busy, state_r, pend_r, buf_full_r}
		: a_iss ? {16'h0000, issued_r}
		: a_rsv ? {16'h0000, rsvd_cnt_r} : 32'h0000_0000;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			prdata_r   <= 32'h0000_0000;
			ctrl_en_r  <= CTRL_EN_RST;
			issued_r   <= '0;
			rsvd_cnt_r <= '0;
		end else begin
			pready_r  <= apb_acc;
			pslverr_r <= apb_acc & ~a_hit;
			prdata_r  <= (apb_acc & ~pwrite) ? rd_mux : 32'h0000_0000;
			if (apb_done & pwrite & a_ctrl) begin
				ctrl_en_r <= pwdata[CTRL_EN_BIT];
			end
			if (issue) begin
				issued_r <= issued_r + 1'b1;
			end
			if (issue & d.rsvd) begin
				rsvd_cnt_r <= rsvd_cnt_r + 1'b1;
			end
		end
	end

	// Built-in macro table; no write path reaches it
	macro_expander u_macro (
		.clk          (clk),
		.nrst         (nrst),
		.start        (exp_start),
		.sel          (px[PX_SEL_LSB +: 3]),
		.p4           (px[PX_HI_LSB +: 3]),
		.p3           (px[4:0]),
		.p2           (hw[RX_LSB +: 3]),
		.p1           (hw[RY_LSB +: 3]),
		.p0           (hw[4:0]),
		.busy         (exp_busy),
		.native_valid (native_valid),
		.native_word  (native_word)
	);

	assign prdata              = prdata_r;
	assign pready              = pready_r;
	assign pslverr             = pslverr_r;
	assign fetch_ready         = fetch_ready_r;
	assign redirect            = redirect_r;
	assign dec_valid           = dec_valid_r;
	assign major_opcode        = dec_r.maj;
	assign first_reg_spec      = dec_r.r1;
	assign second_reg_spec     = dec_r.r2;
	assign third_reg_spec      = dec_r.r3;
	assign sub_func            = dec_r.sub;
	assign func_code           = dec_r.func;
	assign imm_value           = dec_r.imm;
	assign imm_width           = dec_r.imm_w;
	assign shift_amount_field  = dec_r.sa;
	assign shift_amount_msb    = dec_r.sa_msb;
	assign full_gpr_number     = dec_r.gpr;
	assign spill_select        = dec_r.spill;
	assign frame_adjust        = dec_r.frame;
	assign extra_saved_regs    = dec_r.xs;
	assign argument_regs_field = dec_r.ar;
	assign is_extended         = dec_r.ext;
	assign mode_swap           = dec_r.swap;
	assign in_delay_slot       = dec_r.slot_instr;
	assign has_delay_slot      = dec_r.has_slot;
	assign reserved_instr      = dec_r.rsvd;
	assign restart_addr        = dec_r.addr;
endmodule
`default_nettype wire

/* compact16_props.sv */
`timescale 1ns/1ps
`default_nettype none
module compact16_props
	import compact16_pkg::*;
(
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       fetch_valid,
	input wire logic       fetch_ready,
	input wire logic       redirect,
	input wire logic       dec_valid,
	input wire logic [4:0] major_opcode,
	input wire logic [4:0] imm_width,
	input wire logic [4:0] shift_amount_field,
	input wire logic       is_extended,
	input wire logic       in_delay_slot,
	input wire logic       has_delay_slot,
	input wire logic       reserved_instr,
	input wire logic       native_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence take_word;
		fetch_valid && fetch_ready;
	endsequence
	sequence issue_of(logic [4:0] opc);
		dec_valid && major_opcode == opc;
	endsequence
	take_busy_a: assert property (take_word |=> !fetch_ready || redirect)
		else $error("word taken but buffer still free");
	short_sa_a: assert property (issue_of(MAJ_SHIFT) ##0 !is_extended |->
		shift_amount_field != 5'h00) else $error("short shift by zero");
	call_slot_a: assert property (issue_of(MAJ_CALL_ABS) ##0 !reserved_instr |->
		has_delay_slot && imm_width == IW_CALL) else $error("call decode wrong");
	br_flow_a: assert property (issue_of(MAJ_BRANCH) ##0 !reserved_instr |->
		!has_delay_slot ##[0:2] redirect) else $error("branch flow wrong");
	slot_end_a: assert property (dec_valid && in_delay_slot |->
		##[0:2] redirect) else $error("no redirect after slot");
	br_width_a: assert property (issue_of(MAJ_BRANCH) ##0 !is_extended |->
		imm_width == IW_ELEVEN) else $error("branch width wrong");
	macro_out_a: assert property (issue_of(MAJ_THREE_REG) ##0 is_extended
		&& !reserved_instr |-> ##[1:2] native_valid) else $error("no macro output");
	pfx_rsvd_a: assert property (issue_of(MAJ_REG_REG) ##0 is_extended |->
		reserved_instr) else $error("prefixed reg-reg not reserved");
endmodule
`default_nettype wire

/* fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
	input  wire logic   clk,
	input  wire logic   nrst,
	input  wire logic   go,
	input  wire logic   fetch_ready,
	output logic        fetch_valid,
	output logic [31:0] fetch_word,
	output logic [31:0] fetch_addr
);
	logic [31:0] mem [8];
	logic [3:0]  ptr_r;
	assign fetch_valid = go && !ptr_r[3];
	assign fetch_addr  = {27'h0, ptr_r[2:0], 2'h0};
	// First halfword in 31:16
	// Idle bus shows inverted data, never a stale word
	assign fetch_word  = fetch_valid ? mem[ptr_r[2:0]] : ~mem[7];
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			ptr_r <= 4'h0;
		else if (fetch_valid && fetch_ready)
			ptr_r <= ptr_r + 4'h1;
	end
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import compact16_pkg::*;
	typedef struct packed {
		logic [4:0]  op;
		logic [3:0]  fl;
		logic [25:0] im;
		logic [4:0]  iw;
		logic [4:0]  sa;
		logic [4:0]  gp;
		logic [8:0]  rg;
		logic [2:0]  xs;
		logic        ex;
		logic [31:0] ra;
	} snap_t;
	localparam logic [4:0] EOP [10] = '{5'h06, 5'h1C, 5'h06, 5'h0C, 5'h0C, 5'h03, 5'h1C,
		5'h02, 5'h1C, 5'h1D};
	localparam logic [3:0] EFL [10] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'hA, 4'h4, 4'h0,
		4'h0, 4'h1};
	logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        go = 1'b0, pready, pslverr, fetch_valid, fetch_ready, redirect, e;
	logic        dec_valid, native_valid, is_extended, mode_swap, in_delay_slot;
	logic        has_delay_slot, reserved_instr;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, native_word, fetch_word, fetch_addr, q, nw;
	logic [4:0]  major_opcode, imm_width, shift_amount_field, full_gpr_number;
	logic [2:0]  first_reg_spec, second_reg_spec, third_reg_spec, extra_saved_regs;
	logic [25:0] imm_value;
	logic [31:0] restart_addr;
	int          mismatches = 0, n_compared = 0, n_dec = 0, n_nat = 0, k;
	snap_t       s [16];
	always #4 clk = ~clk;
	compact16_decoder i_dut (.*, .fetch_skip_first(1'b0), .resolve_valid(1'b0),
		.resolve_taken(1'b0), .sub_func(), .func_code(), .shift_amount_msb(),
		.spill_select(), .frame_adjust(), .argument_regs_field());
	fetch_model i_fetch (.*);
	always @(posedge clk) begin
		if (dec_valid === 1'b1) begin
			s[n_dec[3:0]] = '{major_opcode, {mode_swap, in_delay_slot, has_delay_slot,
				reserved_instr}, imm_value, imm_width, shift_amount_field, full_gpr_number,
				{first_reg_spec, second_reg_spec, third_reg_spec}, extra_saved_regs, is_extended,
				restart_addr};
			n_dec++;
		end
		if (native_valid === 1'b1) begin
			nw = native_word;
			n_nat++;
		end
	end
	task automatic chk(input string nm, input logic [31:0] ev, input logic [31:0] gv);
		n_compared++;
		if (gv !== ev) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, ev, gv);
		end
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Gap cycle after each transfer keeps one write per signal per step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			chk("pready", 1'b1, pready);
		@(posedge clk);
	endtask
	initial begin
		// Slots hold plain ops, prefixed shift msb zero
		i_fetch.mem = '{32'h3140E395, 32'hF0003140, 32'h65E16756, 32'h1C711234,
			32'hE395E395, 32'h1005E395, 32'hF265E385, 32'hF000E80C};
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", {31'h0, CTRL_EN_RST}, q);
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", 1'b1, e);
		apb(1'b1, REG_CTRL, 32'h0);
		go <= 1'b1;
		repeat (8) @(posedge clk);
		chk("idle", 32'h0, n_dec);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", 32'h1, q);
		$display("test registers done");
		apb(1'b1, REG_CTRL, 32'h1);
		for (k = 0; k < 300 && n_dec < 10; k++)
			@(posedge clk);
		repeat (20) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			chk("op", EOP[i], s[i].op);
			chk("flags", EFL[i], s[i].fl);
		end
		chk("sa", SA_ZERO_AS, s[0].sa);
		chk("regs", 9'h0E5, s[1].rg);
		chk("xsa", 5'h00, s[2].sa);
		chk("ext", 1'b1, s[2].ex);
		chk("gpr", 5'h07, s[3].gp);
		chk("gpr", 5'h16, s[4].gp);
		chk("target", {5'h11, 5'h03, 16'h1234}, s[5].im);
		chk("bimm", 26'h0000005, s[7].im);
		chk("bwidth", IW_ELEVEN, s[7].iw);
		chk("sel", 3'h2, s[8].xs);
		chk("native", MACRO_TMPL[2][0] | 32'h00A3_0E14, nw);
		chk("restart", 32'h2, s[1].ra);
		chk("restart", 32'h4, s[2].ra);
		chk("restart", 32'hC, s[5].ra);
		chk("nat count", MACRO_LEN[2], n_nat);
		chk("issued", 32'hA, n_dec);
		apb(1'b0, REG_RSVD, 32'h0);
		chk("rsvd", 32'h1, q);
		apb(1'b0, REG_ISSUED, 32'h0);
		chk("issued reg", 32'hA, q);
		$display("test decode done");
		test_done();
	end
endmodule
bind compact16_decoder compact16_props i_props (.*);
`default_nettype wire
